// ===== rtl/posr_divider.sv
// Clock divider that makes the PCI bus clock from the host clock
`timescale 1ns/1ps
`default_nettype none
module posr_divider #(
    parameter int CW = 3
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Divisor select
    input wire logic [CW-1:0] divisor,
    // Divided clock
    output logic clk_out
);
    // Elaboration check: the divide-by-4 code needs three bits
    if (CW < 3) begin : g_cw_check
        $error("posr_divider: CW too small");
    end
    // Divider state: count and output level
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic out;
    } posr_div_t;
    posr_div_t st;
    posr_div_t next_st;
    // Next state: output high for the first divisor/2 counts (rounded down) of each period
    always_comb begin
        next_st = st;
        if (st.cnt >= divisor - CW'(1)) begin
            next_st.cnt = '0;
        end else begin
            next_st.cnt = st.cnt + CW'(1);
        end
        next_st.out = (next_st.cnt < (divisor >> 1));
    end
    // State register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign clk_out = st.out;
endmodule // posr_divider
`default_nettype wire

// ===== rtl/posr_pkg.sv
// Package of offsets, field positions and codes for the power-on strap registers
package posr_pkg;
    // ------------------------------------------------------------------
    // I/O port pair and register offsets
    // ------------------------------------------------------------------
    localparam logic [15:0] INDEX_PORT = 16'h0022;
    localparam logic [15:0] DATA_PORT = 16'h0023;
    localparam logic [7:0] OFF_CAPTURE_0 = 8'h4A;
    localparam logic [7:0] OFF_CAPTURE_1 = 8'h4B;
    localparam logic [7:0] OFF_CAPTURE_2 = 8'h4C;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int C0_PLL_HI = 7;
    localparam int C0_PLL_LO = 6;
    localparam int C0_BUS_SEL = 5;
    localparam int C0_DIVISION = 4;
    localparam int C0_MEM_SYNC = 2;
    localparam int C0_DIV2_HI = 1;
    localparam int C0_DIV2_LO = 0;
    localparam int C1_RSV_HI = 5;
    localparam int C1_RSV_LO = 2;
    localparam int C2_CPU_MODE = 7;
    localparam int C2_DOT_DIR = 4;
    localparam int C2_DIV2 = 1;
    // ------------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------------
    localparam logic [1:0] PLL_16_32 = 2'h0;
    localparam logic [1:0] PLL_32_64 = 2'h1;
    localparam logic [2:0] DIV_BY_4 = 3'h4;
    localparam logic [2:0] DIV_BY_3 = 3'h3;
    localparam logic [2:0] DIV_BY_2 = 3'h2;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // Strap reader states, Gray order
    typedef enum logic [1:0] {
        POSR_ST_RESET = 2'h0,
        POSR_ST_CAPTURE = 2'h1,
        POSR_ST_RUN = 2'h3
    } posr_state_t;
endpackage

// ===== rtl/posr_straps.sv
// Power-on strap capture registers with index/data port access
//
// Functional notes
// R1: Registers 4A-4C behind ports 22/23.
// R2: Register 0 holds captured strap levels.
// R3: Register 1 bits 5-2 hold reserved group.
// R4: Register 0 bits 7-6 choose PLL range.
// R5: Bus select bit 5, local-bus variant only.
// R6: PCI clock divides host clock 4/3/2.
// R7: Bits 1-0 mirror second divisor strap.
// R8: Bit 2 reports memory-sync strap.
// R9: Register 2 bit 4 sets dot clock direction.
// R10: Dot clock bit is software writable.
// R11: Register 2 bit 7 shows CPU mode.
// R12: CPU mode low x1, high x2.
// R13: Register 2 bit 1 per variant.
// R14: Capture once at reset release, then hold.
// R15: Reserved read zero; strap writes ignored.
`timescale 1ns/1ps
`default_nettype none
module posr_straps #(
    parameter bit LOCAL_BUS_VARIANT = 1'b1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Strap pins
    input wire logic [1:0] pll_range_straps,
    input wire logic bus_select_strap,
    input wire logic clock_division_strap,
    input wire logic second_divisor_strap,
    input wire logic memory_sync_strap,
    input wire logic dot_clock_dir_strap,
    input wire logic cpu_mode_strap,
    input wire logic [3:0] reserved_strap_group,
    // I/O port access
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // Configuration outputs
    output logic [1:0] pll_range,
    output logic mem_sync,
    output logic cpu_clk_x2,
    output logic isa_mode,
    // Dot clock pad enable, low while the pad drives
    output logic dot_clock_oe_n,
    // PCI bus clock
    output logic pci_bus_clock
);
    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic [1:0] rst_sync; // Two-stage release
    logic rst_n;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        posr_pkg::posr_state_t fsm;
        logic [7:0] index; // Index latched at port 22
        logic [7:0] cap0;
        logic [7:0] cap1;
        logic [7:0] cap2;
        logic [7:0] rdata;
        logic [2:0] divisor;
        logic isa; // ISA-mode output, kept in a flop of its own
        logic oe_n; // Dot clock pad enable, low while driving
    } posr_state_s_t;
    posr_state_s_t st;
    posr_state_s_t next_st;
    // Combines the straps into register 0 image
    function automatic logic [7:0] posr_img0();
        logic [7:0] v;
        v = posr_pkg::READ_ZERO;
        v[posr_pkg::C0_PLL_HI:posr_pkg::C0_PLL_LO] = pll_range_straps; // [R2] [R4]
        if (LOCAL_BUS_VARIANT) begin
            v[posr_pkg::C0_BUS_SEL] = bus_select_strap; // [R5]
            v[posr_pkg::C0_DIV2_HI] = second_divisor_strap; // [R7]
            v[posr_pkg::C0_DIV2_LO] = second_divisor_strap; // [R7]
        end
        v[posr_pkg::C0_DIVISION] = clock_division_strap; // [R6]
        v[posr_pkg::C0_MEM_SYNC] = memory_sync_strap; // [R8]
        return v;
    endfunction
    // Register select decode, used for reads and writes
    function automatic logic [1:0] posr_sel(input logic [7:0] idx);
        case (idx)
            posr_pkg::OFF_CAPTURE_0: return 2'h1;
            posr_pkg::OFF_CAPTURE_1: return 2'h2;
            posr_pkg::OFF_CAPTURE_2: return 2'h3;
            default: return 2'h0;
        endcase
    endfunction
    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [7:0] img2;
        img2 = posr_pkg::READ_ZERO;
        next_st = st;
        case (st.fsm)
            posr_pkg::POSR_ST_RESET: begin
                // First clock after release: move to capture; straps are taken on the next clock
                next_st.fsm = posr_pkg::POSR_ST_CAPTURE;
            end
            posr_pkg::POSR_ST_CAPTURE: begin
                // Single sample; values then hold until next reset, except the writable dot clock bit
                next_st.cap0 = posr_img0(); // [R14]
                next_st.cap1 = posr_pkg::READ_ZERO;
                next_st.cap1[posr_pkg::C1_RSV_HI:posr_pkg::C1_RSV_LO] =
                    reserved_strap_group; // [R3]
                if (LOCAL_BUS_VARIANT) begin
                    img2[posr_pkg::C2_CPU_MODE] = cpu_mode_strap; // [R11] [R12]
                end else begin
                    img2[posr_pkg::C2_DIV2] = second_divisor_strap; // [R13]
                end
                img2[posr_pkg::C2_DOT_DIR] = dot_clock_dir_strap; // [R9]
                next_st.cap2 = img2;
                // Divisor selection from division straps
                if (!clock_division_strap) begin
                    next_st.divisor = posr_pkg::DIV_BY_4; // [R6]
                end else if (!second_divisor_strap) begin
                    next_st.divisor = posr_pkg::DIV_BY_3; // [R6]
                end else begin
                    next_st.divisor = posr_pkg::DIV_BY_2; // [R6]
                end
                next_st.fsm = posr_pkg::POSR_ST_RUN;
            end
            posr_pkg::POSR_ST_RUN: begin
                // Index port write
                if (io_wr && io_addr == posr_pkg::INDEX_PORT) begin
                    next_st.index = io_wdata; // [R1]
                end
                // Only the dot clock bit takes writes
                if (io_wr && io_addr == posr_pkg::DATA_PORT &&
                    posr_sel(st.index) == 2'h3) begin
                    next_st.cap2[posr_pkg::C2_DOT_DIR] =
                        io_wdata[posr_pkg::C2_DOT_DIR]; // [R10] [R15]
                end
                // Data port read; unknown index reads zero
                if (io_rd && io_addr == posr_pkg::DATA_PORT) begin
                    case (posr_sel(st.index))
                        2'h1: next_st.rdata = st.cap0; // [R1]
                        2'h2: next_st.rdata = st.cap1; // [R1]
                        2'h3: next_st.rdata = st.cap2; // [R1]
                        default: next_st.rdata = posr_pkg::READ_ZERO; // [R15]
                    endcase
                end else if (io_rd && io_addr == posr_pkg::INDEX_PORT) begin
                    next_st.rdata = st.index;
                end
            end
            default: begin
                next_st.fsm = posr_pkg::POSR_ST_RESET;
            end
        endcase
        // Decoded pins follow their register bits in the same cycle, no gate on the pin
        next_st.isa = ~next_st.cap0[posr_pkg::C0_BUS_SEL]; // [R5]
        next_st.oe_n = ~next_st.cap2[posr_pkg::C2_DOT_DIR]; // [R9]
    end
    // State register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            // In reset the pad stays undriven and the bus reads as ISA
            st <= '{fsm: posr_pkg::POSR_ST_RESET, divisor: posr_pkg::DIV_BY_4,
                    isa: 1'b1, oe_n: 1'b1, default: '0};
        end else begin
            st <= next_st;
        end
    end
    // ------------------------------------------------------------------
    // Outputs, all registered
    // ------------------------------------------------------------------
    assign io_rdata = st.rdata;
    assign pll_range = st.cap0[posr_pkg::C0_PLL_HI:posr_pkg::C0_PLL_LO]; // [R4]
    assign mem_sync = st.cap0[posr_pkg::C0_MEM_SYNC]; // [R8]
    assign cpu_clk_x2 = st.cap2[posr_pkg::C2_CPU_MODE]; // [R12]
    assign isa_mode = st.isa; // [R5]
    assign dot_clock_oe_n = st.oe_n; // [R9]
    // PCI clock generator
    posr_divider #(.CW(3)) u_div (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .divisor(st.divisor),
        .clk_out(pci_bus_clock)
    );
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    capture_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R14]
        st.fsm == posr_pkg::POSR_ST_RUN |=> $stable(st.cap0) && $stable(st.cap1))
        else $error("strap capture changed after reset");
    dot_write_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R10]
        (st.fsm == posr_pkg::POSR_ST_RUN && io_wr && io_addr == posr_pkg::DATA_PORT
         && st.index == posr_pkg::OFF_CAPTURE_2)
        |=> st.cap2[posr_pkg::C2_DOT_DIR] == $past(io_wdata[posr_pkg::C2_DOT_DIR]))
        else $error("dot clock bit not written");
    dot_pad_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R9]
        dot_clock_oe_n != st.cap2[posr_pkg::C2_DOT_DIR])
        else $error("dot clock pad direction wrong");
    reserved_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R15]
        st.cap1[7:6] == 2'h0 && st.cap1[1:0] == 2'h0 && st.cap2[6:5] == 2'h0)
        else $error("reserved bit not zero");
    unmapped_read_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R1]
        (st.fsm == posr_pkg::POSR_ST_RUN && io_rd && io_addr == posr_pkg::DATA_PORT
         && posr_sel(st.index) == 2'h0) |=> io_rdata == posr_pkg::READ_ZERO)
        else $error("unmapped index did not read zero");
    read_c0_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R2]
        (st.fsm == posr_pkg::POSR_ST_RUN && io_rd && io_addr == posr_pkg::DATA_PORT
         && st.index == posr_pkg::OFF_CAPTURE_0) |=> io_rdata == $past(st.cap0))
        else $error("register 0 read wrong");
    pci_divisor_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R6]
        st.fsm == posr_pkg::POSR_ST_RUN |-> (!st.cap0[posr_pkg::C0_DIVISION] ?
        st.divisor == posr_pkg::DIV_BY_4 : st.divisor != posr_pkg::DIV_BY_4))
        else $error("PCI divisor does not match strap");
    capture_once_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R14]
        st.fsm == posr_pkg::POSR_ST_CAPTURE |=> st.fsm == posr_pkg::POSR_ST_RUN)
        else $error("capture not finished in one cycle");
    run_c: cover property (@(posedge core_clk) disable iff (!rst_n)
        st.fsm == posr_pkg::POSR_ST_RUN);
    dot_wr_c: cover property (@(posedge core_clk) disable iff (!rst_n)
        io_wr && io_addr == posr_pkg::DATA_PORT && st.index == posr_pkg::OFF_CAPTURE_2);
    rd_c: cover property (@(posedge core_clk) disable iff (!rst_n)
        io_rd && io_addr == posr_pkg::DATA_PORT);
endmodule // posr_straps
`default_nettype wire

// ===== tb/posr_strap_board.sv
// Board strap resistors feeding the memory data pins at reset
`timescale 1ns/1ps
`default_nettype none
module posr_strap_board (
    // Strap setting chosen by the bench
    input wire logic [11:0] level,
    // Strap pins
    output logic [1:0] pll_range_straps,
    output logic bus_select_strap,
    output logic clock_division_strap,
    output logic second_divisor_strap,
    output logic memory_sync_strap,
    output logic dot_clock_dir_strap,
    output logic cpu_mode_strap,
    output logic [3:0] reserved_strap_group
);
    // Resistors hold static levels; no timing of their own to model
    assign {pll_range_straps, bus_select_strap, clock_division_strap, second_divisor_strap,
            memory_sync_strap, dot_clock_dir_strap, cpu_mode_strap,
            reserved_strap_group} = level;
endmodule // posr_strap_board
`default_nettype wire

// ===== tb/power_on_strap_registers_tb.sv
// Self-checking bench for the power-on strap registers
`timescale 1ns/1ps
`default_nettype none
module power_on_strap_registers_tb;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [11:0] level = 12'h000; // Strap setting for the board model
    logic [15:0] io_addr = 16'h0000;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic [7:0] io_wdata = 8'h00;
    logic [7:0] io_rdata;
    logic [1:0] pll_range, prs;
    logic mem_sync, cpu_clk_x2, isa_mode, dot_clock_oe_n, pci_bus_clock;
    logic bss, cds, sds, mss, dds, cms;
    logic [3:0] rsg;
    int errors = 0;
    int compares = 0;
    initial forever #12.5 core_clk = ~core_clk;
    posr_strap_board board_u (.level(level), .pll_range_straps(prs), .bus_select_strap(bss),
        .clock_division_strap(cds), .second_divisor_strap(sds), .memory_sync_strap(mss),
        .dot_clock_dir_strap(dds), .cpu_mode_strap(cms), .reserved_strap_group(rsg));
    posr_straps dut_u (.core_clk(core_clk), .rstn(rstn), .pll_range_straps(prs),
        .bus_select_strap(bss), .clock_division_strap(cds), .second_divisor_strap(sds),
        .memory_sync_strap(mss), .dot_clock_dir_strap(dds), .cpu_mode_strap(cms),
        .reserved_strap_group(rsg), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .pll_range(pll_range), .mem_sync(mem_sync),
        .cpu_clk_x2(cpu_clk_x2), .isa_mode(isa_mode), .dot_clock_oe_n(dot_clock_oe_n),
        .pci_bus_clock(pci_bus_clock));
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One-cycle strobe, released at the edge that takes it
    task automatic port_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge core_clk);
        io_wr <= 1'b0;
    endtask
    task automatic reg_wr(input logic [7:0] off, input logic [7:0] d);
        port_wr(posr_pkg::INDEX_PORT, off);
        port_wr(posr_pkg::DATA_PORT, d);
    endtask
    task automatic reg_rd(input logic [7:0] off, output logic [7:0] d);
        port_wr(posr_pkg::INDEX_PORT, off);
        @(posedge core_clk);
        io_addr <= posr_pkg::DATA_PORT;
        io_rd <= 1'b1;
        @(posedge core_clk);
        io_rd <= 1'b0;
        @(posedge core_clk);
        #1 d = io_rdata;
    endtask
    // Register image the straps should produce, local-bus variant
    function automatic logic [7:0] img(input int k, input logic [11:0] lv);
        if (k == 0) return {lv[11:10], lv[9], lv[8], 1'b0, lv[6], lv[7], lv[7]};
        if (k == 1) return {2'b00, lv[3:0], 2'b00};
        return {lv[4], 2'b00, lv[5], 4'h0};
    endfunction
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    // Reset with a strap pattern, then check registers, outputs, divisor
    task automatic capture_case(input logic [11:0] lv);
        logic [7:0] r;
        logic p;
        int n;
        @(posedge core_clk);
        level <= lv;
        rstn <= 1'b0;
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (6) @(posedge core_clk);
        reg_rd(posr_pkg::OFF_CAPTURE_0, r);
        chk("reg_4a", img(0, lv), r);
        reg_rd(posr_pkg::OFF_CAPTURE_1, r);
        chk("reg_4b", img(1, lv), r);
        reg_rd(posr_pkg::OFF_CAPTURE_2, r);
        chk("reg_4c", img(2, lv), r);
        chk("pll_range", {6'h00, lv[11:10]}, {6'h00, pll_range});
        chk("cfg_bits", {4'h0, lv[6], lv[4], ~lv[9], ~lv[5]},
            {4'h0, mem_sync, cpu_clk_x2, isa_mode, dot_clock_oe_n});
        p = pci_bus_clock;
        n = 0;
        // Cycles between two rising edges of the divided clock
        for (int i = 0; i < 24; i++) begin
            @(posedge core_clk);
            #1;
            if (!p && pci_bus_clock) begin
                if (n > 0) break;
                n = 1;
            end else if (n > 0) begin
                n++;
            end
            p = pci_bus_clock;
        end
        chk("pci_period", !lv[8] ? 8'h04 : (lv[7] ? 8'h02 : 8'h03), n[7:0]);
    endtask
    // Software writes, strap hold and unmapped index after a capture
    task automatic write_case(input logic [11:0] lv);
        logic [7:0] r;
        reg_wr(posr_pkg::OFF_CAPTURE_2, 8'h00);
        reg_rd(posr_pkg::OFF_CAPTURE_2, r);
        chk("reg_4c_clr", {lv[4], 7'h00}, r);
        chk("oe_n_clr", 8'h01, {7'h00, dot_clock_oe_n});
        reg_wr(posr_pkg::OFF_CAPTURE_2, 8'hFF);
        reg_rd(posr_pkg::OFF_CAPTURE_2, r);
        chk("reg_4c_set", {lv[4], 2'b00, 1'b1, 4'h0}, r);
        chk("oe_n_set", 8'h00, {7'h00, dot_clock_oe_n});
        // Straps move after capture; registers must not follow
        @(posedge core_clk);
        level <= ~lv;
        reg_wr(posr_pkg::OFF_CAPTURE_0, ~img(0, lv));
        reg_wr(posr_pkg::OFF_CAPTURE_1, 8'hFF);
        reg_rd(posr_pkg::OFF_CAPTURE_0, r);
        chk("reg_4a_hold", img(0, lv), r);
        reg_rd(posr_pkg::OFF_CAPTURE_1, r);
        chk("reg_4b_hold", img(1, lv), r);
        reg_wr(8'h10, 8'hFF);
        reg_rd(8'h10, r);
        chk("unmapped", 8'h00, r);
        // Index port reads back the last index written
        @(posedge core_clk);
        io_addr <= posr_pkg::INDEX_PORT;
        io_rd <= 1'b1;
        @(posedge core_clk);
        io_rd <= 1'b0;
        @(posedge core_clk);
        #1 chk("index_rd", 8'h10, io_rdata);
    endtask
    // ----------------------------------------------------------------
    // Run control
    // ----------------------------------------------------------------
    task automatic summarize;
        if (errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        capture_case(12'h000);
        capture_case(12'h55A);
        capture_case(12'hFFF);
        capture_case(12'hAA5);
        write_case(12'hAA5);
        summarize();
    end
    // Whole run is under two hundred cycles; this cuts a hang short
    initial begin
        #(25 * 5000);
        errors++;
        summarize();
    end
endmodule // power_on_strap_registers_tb
`default_nettype wire
